// ===== msc_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the symbol counter. Assumes byte-wide registers, one per aligned word.
 */
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

// ------
// Address map
// ------
`define MSC_ADDR_W 8
`define MSC_GRP_COUNT 3'h0
`define MSC_GRP_SFD 3'h1
`define MSC_GRP_BEACON 3'h2
`define MSC_GRP_CMP1 3'h3
`define MSC_GRP_CMP2 3'h4
`define MSC_GRP_CMP3 3'h5
`define MSC_OFF_CTRL0 8'h60
`define MSC_OFF_MATCH 8'h64
`define MSC_OFF_RELSRC 8'h68
`define MSC_OFF_STATUS 8'h6C
`define MSC_OFF_FLAGS 8'h70
`define MSC_OFF_MASK 8'h74

// ------
// Field positions
// ------
`define MSC_CTRL0_STAMP_EN 0
`define MSC_CTRL0_SRC_RTC 1
`define MSC_CTRL0_MANUAL_BC 2
`define MSC_MATCH_EN_LSB 0
`define MSC_MATCH_REL_LSB 4
`define MSC_IRQ_CMP_LSB 0
`define MSC_IRQ_OVF 3
`define MSC_IRQ_BO 4
`define MSC_STAT_BUSY 0
`define MSC_STAT_RTC 1

// ------
// Reset values and constants
// ------
`define MSC_WORD_RST 32'h0000_0000
`define MSC_PAN_BCAST 16'hFFFF

// ------
// Timing
// ------
`define MSC_CLK_HZ 100000000
`define MSC_SYM_HZ 62500
`define MSC_RTC_HZ 32768
`define MSC_SYM_US 16
`define MSC_BO_US 320
`define MSC_SYM_DIV (`MSC_CLK_HZ / `MSC_SYM_HZ)
`define MSC_BO_SYMS (`MSC_BO_US / `MSC_SYM_US)

`endif

// ===== msc_pkg.sv
/*
 * Types shared by the symbol counter modules.
 * Assumes nothing of its surroundings.
 */
package msc_pkg;
    typedef enum logic {
        msc_bus_idle = 1'h0,
        msc_bus_ack = 1'h1
    } msc_bus_st_t;

    typedef enum logic [1:0] {
        msc_rel_beacon = 2'h0,
        msc_rel_tx = 2'h1,
        msc_rel_rx = 2'h2
    } msc_rel_src_t;
endpackage

// ===== msc_tick_if.sv
/*
 * Tick interface between the counter core and its tick generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface msc_tick_if;
    logic use_rtc;
    logic presc_clr;
    logic tick;
    modport gen(input use_rtc, input presc_clr, output tick);
    modport user(output use_rtc, output presc_clr, input tick);
endinterface
`default_nettype wire

// ===== msc_tick_gen.sv
/*
 * Symbol tick generator: crystal prescaler and corrected RTC path.
 * Assumes rtc_tick is a one-cycle pulse per RTC period, synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.svh"
module msc_tick_gen #(
    parameter int unsigned DIV = `MSC_SYM_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rtc_tick,
    msc_tick_if.gen tif
);
    localparam int PW = $clog2(DIV);
    localparam int AW = $clog2(`MSC_RTC_HZ);

    logic [PW-1:0] presc_r;
    logic [AW-1:0] acc_r;
    logic [1:0] pend_r;
    logic [AW+1:0] acc_sum;
    logic xtal_tick;

    assign xtal_tick = (presc_r == PW'(DIV - 1));
    assign acc_sum = {2'h0, acc_r} + (AW + 2)'(`MSC_SYM_HZ);
    assign tif.tick = tif.use_rtc ? (pend_r != 2'h0) : xtal_tick;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_r <= '0;
        end else if (tif.presc_clr || tif.use_rtc || xtal_tick) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_r + PW'(1);
        end
    end

    // Each RTC edge is worth a fractional number of symbols; the remainder
    // is carried so the count never drifts by a whole symbol.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= '0;
            pend_r <= 2'h0;
        end else begin
            if (tif.use_rtc && rtc_tick) begin
                acc_r <= acc_sum[AW-1:0];
            end
            pend_r <= pend_r - 2'((tif.use_rtc && pend_r != 2'h0) ? 1 : 0)
                + ((tif.use_rtc && rtc_tick) ? acc_sum[AW+1:AW] : 2'h0);
        end
    end
endmodule
`default_nettype wire

// ===== msc_compare.sv
/*
 * One compare unit in absolute or relative mode.
 * Assumes step pulses in the cycle after the count has changed.
 */
`timescale 1ns/1ps
`default_nettype none
module msc_compare #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] count,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] base,
    input wire logic enable,
    input wire logic relative,
    input wire logic step,
    output logic match
);
    logic [W-1:0] target;

    assign target = relative ? base + value : value;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match <= 1'h0;
        end else begin
            match <= enable && step && (count == target);
        end
    end
endmodule
`default_nettype wire

// ===== msc_symbol_counter.sv
/*
 * Symbol counter top: Avalon-MM register slave, 32-bit symbol count,
 * SFD and beacon stamps, three compare units, backoff slot counter and
 * event flags. Assumes radio event inputs are one-cycle pulses synchronous
 * to clk and rtc_tick is one pulse per RTC period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.svh"
// What this block does
// [R01] 32-bit count advancing on 62.5 kHz tick
// [R02] RTC ticks corrected, error below one symbol
// [R03] Low byte read captures all 32 bits
// [R04] Every byte access two clocks, one wait cycle
// [R05] Low byte write loads assembled 32-bit value
// [R06] RTC load waits tick, crystal load immediate
// [R07] Update-pending flag set while load pending
// [R08] Software avoids access and sleep while pending
// [R09] Overflow event on wrap to zero
// [R10] SFD stamp valid after nonzero length byte
// [R11] SFD and beacon frame stamp capture only when stamp enable set; manual capture not gated
// [R12] Beacon stamp from valid beacon, PAN matched
// [R13] Manual capture bit copies count, self-clears
// [R14] Beacon stamp writable by software
// [R15] Three compare units, own value and mode
// [R16] Absolute mode matches count equal value
// [R17] Relative mode matches stamp plus value
// [R18] Software uses offsets beyond beacon duration
// [R19] Flags set always, requests gated by mask
// [R20] Flag clears on acknowledge or written one
// [R21] Every enabled event raises wake request
// [R22] Backoff event every 20 symbols, radio on
// [R23] Sleep switches to RTC, wake restores, prescaler cleared
// [R24] Relative source select: beacon, transmit, receive
// [R25] Separate flags, masks for five events
module msc_symbol_counter #(
    parameter int unsigned SYM_DIV = `MSC_SYM_DIV,
    parameter int unsigned BO_SYMS = `MSC_BO_SYMS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`MSC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rtc_tick,
    input wire logic trx_sleep,
    input wire logic trx_off,
    input wire logic rx_sfd_det,
    input wire logic rx_len_strobe,
    input wire logic [6:0] rx_len,
    input wire logic rx_end,
    input wire logic rx_fcs_ok,
    input wire logic rx_is_beacon,
    input wire logic [15:0] rx_src_pan,
    input wire logic [7:0] network_ident_low,
    input wire logic [7:0] network_ident_high,
    input wire logic [31:0] tx_frame_stamp,
    input wire logic [4:0] irq_ack,
    output logic [4:0] irq_req,
    output logic wake_req
);
    localparam int BW = $clog2(BO_SYMS);

    // ------
    // Declarations
    // ------
    msc_pkg::msc_bus_st_t bus_st_r;
    logic bus_req;
    logic bus_take;
    logic wr_go;
    logic rd_first;
    logic [7:0] wd;
    logic [2:0] grp;
    logic [1:0] bsel;
    logic in_wide;
    logic wide_ll_wr;
    logic [31:0] wide_val;
    logic [31:0] wide_wr;
    logic [31:0] rd_mux;
    logic [31:0] temp_r;
    logic [31:0] readdata_r;
    logic [31:0] count_r;
    logic [31:0] load_val_r;
    logic pending_r;
    logic load_go;
    logic step_r;
    logic ovf_ev;
    logic [31:0] sfd_pend_r;
    logic [31:0] sfd_stamp_r;
    logic [31:0] beacon_r;
    logic [31:0] cmp_val_r [3];
    logic stamp_en_r;
    logic src_sel_r;
    logic manual_r;
    logic [2:0] cmp_en_r;
    logic [2:0] cmp_rel_r;
    logic [5:0] relsrc_r;
    logic use_rtc_prev_r;
    logic [BW-1:0] bo_r;
    logic bo_run;
    logic bo_ev;
    logic [2:0] cmp_ev;
    logic [4:0] flags_r;
    logic [4:0] mask_r;
    logic [4:0] ev_set;
    logic [4:0] ev_clr;
    logic pan_ok;

    msc_tick_if tif();

    msc_tick_gen #(.DIV(SYM_DIV)) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .rtc_tick(rtc_tick),
        .tif(tif.gen)
    );

    // ------
    // Bus slave
    // ------
    // Every access takes one wait cycle: the request is decoded at the
    // first edge and answered at the second.
    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && (bus_st_r == msc_pkg::msc_bus_idle); // see [R04]
    assign bus_take = bus_req && (bus_st_r == msc_pkg::msc_bus_ack);
    assign rd_first = avs_read && (bus_st_r == msc_pkg::msc_bus_idle);
    assign wr_go = bus_take && avs_write && avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign grp = avs_address[6:4];
    assign bsel = avs_address[3:2];
    assign in_wide = !avs_address[7] && (grp <= `MSC_GRP_CMP3);
    assign wide_ll_wr = wr_go && in_wide && (bsel == 2'h0);
    assign wide_wr = {temp_r[31:8], wd};
    assign avs_readdata = readdata_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_st_r <= msc_pkg::msc_bus_idle;
        end else if (bus_take) begin
            bus_st_r <= msc_pkg::msc_bus_idle;
        end else if (bus_req) begin
            bus_st_r <= msc_pkg::msc_bus_ack;
        end
    end

    always_comb begin
        unique case (grp)
            `MSC_GRP_COUNT: wide_val = count_r;
            `MSC_GRP_SFD: wide_val = sfd_stamp_r;
            `MSC_GRP_BEACON: wide_val = beacon_r;
            `MSC_GRP_CMP1: wide_val = cmp_val_r[0];
            `MSC_GRP_CMP2: wide_val = cmp_val_r[1];
            `MSC_GRP_CMP3: wide_val = cmp_val_r[2];
            default: wide_val = `MSC_WORD_RST;
        endcase
    end

    always_comb begin
        rd_mux = `MSC_WORD_RST;
        if (in_wide) begin
            if (bsel == 2'h0) begin
                rd_mux[7:0] = wide_val[7:0];
            end else begin
                rd_mux[7:0] = 8'(temp_r >> {bsel, 3'h0}); // see [R03]
            end
        end else begin
            case (avs_address)
                `MSC_OFF_CTRL0: begin
                    rd_mux[`MSC_CTRL0_STAMP_EN] = stamp_en_r;
                    rd_mux[`MSC_CTRL0_SRC_RTC] = tif.use_rtc;
                    rd_mux[`MSC_CTRL0_MANUAL_BC] = manual_r;
                end
                `MSC_OFF_MATCH: begin
                    rd_mux[`MSC_MATCH_EN_LSB +: 3] = cmp_en_r;
                    rd_mux[`MSC_MATCH_REL_LSB +: 3] = cmp_rel_r;
                end
                `MSC_OFF_RELSRC: rd_mux[5:0] = relsrc_r;
                `MSC_OFF_STATUS: begin
                    rd_mux[`MSC_STAT_BUSY] = pending_r;
                    rd_mux[`MSC_STAT_RTC] = tif.use_rtc;
                end
                `MSC_OFF_FLAGS: rd_mux[4:0] = flags_r;
                `MSC_OFF_MASK: rd_mux[4:0] = mask_r;
                default: rd_mux = `MSC_WORD_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata_r <= `MSC_WORD_RST;
        end else if (rd_first) begin
            readdata_r <= rd_mux;
        end
    end

    // One holding register serves every 32-bit register, for both reads
    // and writes, so interleaving two wide accesses corrupts both.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_r <= `MSC_WORD_RST;
        end else if (rd_first && in_wide && bsel == 2'h0) begin
            temp_r <= wide_val; // see [R03]
        end else if (wr_go && in_wide && bsel != 2'h0) begin
            case (bsel)
                2'h1: temp_r[15:8] <= wd;
                2'h2: temp_r[23:16] <= wd;
                default: temp_r[31:24] <= wd;
            endcase
        end
    end

    // ------
    // Control registers
    // ------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stamp_en_r <= 1'h0;
            src_sel_r <= 1'h0;
            manual_r <= 1'h0;
        end else begin
            manual_r <= 1'h0; // see [R13]
            if (wr_go && avs_address == `MSC_OFF_CTRL0) begin
                stamp_en_r <= wd[`MSC_CTRL0_STAMP_EN];
                manual_r <= wd[`MSC_CTRL0_MANUAL_BC];
                if (!trx_sleep) begin
                    src_sel_r <= wd[`MSC_CTRL0_SRC_RTC]; // see [R23]
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_en_r <= 3'h0;
            cmp_rel_r <= 3'h0;
            relsrc_r <= 6'h00;
            mask_r <= 5'h00;
        end else if (wr_go) begin
            if (avs_address == `MSC_OFF_MATCH) begin
                cmp_en_r <= wd[`MSC_MATCH_EN_LSB +: 3];
                cmp_rel_r <= wd[`MSC_MATCH_REL_LSB +: 3]; // see [R15]
            end
            if (avs_address == `MSC_OFF_RELSRC) begin
                relsrc_r <= wd[5:0]; // see [R24]
            end
            if (avs_address == `MSC_OFF_MASK) begin
                mask_r <= wd[4:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_val_r[0] <= `MSC_WORD_RST;
            cmp_val_r[1] <= `MSC_WORD_RST;
            cmp_val_r[2] <= `MSC_WORD_RST;
        end else if (wide_ll_wr) begin
            if (grp == `MSC_GRP_CMP1) cmp_val_r[0] <= wide_wr;
            if (grp == `MSC_GRP_CMP2) cmp_val_r[1] <= wide_wr;
            if (grp == `MSC_GRP_CMP3) cmp_val_r[2] <= wide_wr;
        end
    end

    // ------
    // Clock source and symbol count
    // ------
    assign tif.use_rtc = src_sel_r || trx_sleep; // see [R23]
    assign tif.presc_clr = use_rtc_prev_r && !tif.use_rtc; // see [R23]
    // A crystal-sourced load needs no tick; an RTC load waits for one.
    assign load_go = pending_r && (!tif.use_rtc || tif.tick); // see [R06]
    assign ovf_ev = tif.tick && !load_go && (count_r == 32'hFFFF_FFFF); // see [R09]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            use_rtc_prev_r <= 1'h0;
        end else begin
            use_rtc_prev_r <= tif.use_rtc;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_r <= 1'h0;
            load_val_r <= `MSC_WORD_RST;
        end else if (wide_ll_wr && grp == `MSC_GRP_COUNT) begin
            pending_r <= 1'h1; // see [R07]
            load_val_r <= wide_wr; // see [R05]
        end else if (load_go) begin
            pending_r <= 1'h0; // see [R07]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= `MSC_WORD_RST;
            step_r <= 1'h0;
        end else begin
            step_r <= load_go || tif.tick;
            if (load_go) begin
                count_r <= load_val_r; // see [R05]
            end else if (tif.tick) begin
                count_r <= count_r + 32'h1; // see [R01] [R02]
            end
        end
    end

    // ------
    // SFD and beacon stamps
    // ------
    assign pan_ok = (rx_src_pan == {network_ident_high, network_ident_low})
        || ({network_ident_high, network_ident_low} == `MSC_PAN_BCAST);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sfd_pend_r <= `MSC_WORD_RST;
            sfd_stamp_r <= `MSC_WORD_RST;
        end else if (stamp_en_r) begin // see [R11]
            if (rx_sfd_det) begin
                sfd_pend_r <= count_r;
            end
            if (rx_len_strobe && rx_len != 7'h00) begin
                sfd_stamp_r <= sfd_pend_r; // see [R10]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            beacon_r <= `MSC_WORD_RST;
        end else if (wide_ll_wr && grp == `MSC_GRP_BEACON) begin
            beacon_r <= wide_wr; // see [R14]
        end else if (manual_r) begin
            beacon_r <= count_r; // see [R13]
        end else if (stamp_en_r && rx_end && rx_is_beacon && rx_fcs_ok && pan_ok) begin
            beacon_r <= sfd_stamp_r; // see [R12] [R11]
        end
    end

    // ------
    // Compare units
    // ------
    for (genvar u = 0; u < 3; u++) begin : g_cmp
        logic [31:0] base;
        always_comb begin
            case (msc_pkg::msc_rel_src_t'(relsrc_r[2*u +: 2])) // see [R24]
                msc_pkg::msc_rel_tx: base = tx_frame_stamp;
                msc_pkg::msc_rel_rx: base = sfd_stamp_r;
                default: base = beacon_r;
            endcase
        end
        msc_compare #(.W(32)) u_cmp (
            .clk(clk),
            .rst_b(rst_b),
            .count(count_r),
            .value(cmp_val_r[u]),
            .base(base),
            .enable(cmp_en_r[u]),
            .relative(cmp_rel_r[u]),
            .step(step_r),
            .match(cmp_ev[u])
        ); // see [R16] [R17]
    end

    // ------
    // Backoff slot counter
    // ------
    // Runs only on crystal-derived ticks with the radio awake.
    assign bo_run = tif.tick && !tif.use_rtc && !trx_sleep && !trx_off; // see [R22]
    assign bo_ev = bo_run && (bo_r == BW'(BO_SYMS - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bo_r <= '0;
        end else if (bo_ev) begin
            bo_r <= '0;
        end else if (bo_run) begin
            bo_r <= bo_r + BW'(1); // see [R22]
        end
    end

    // ------
    // Event flags
    // ------
    always_comb begin
        ev_set = 5'h00;
        ev_set[`MSC_IRQ_CMP_LSB +: 3] = cmp_ev;
        ev_set[`MSC_IRQ_OVF] = ovf_ev;
        ev_set[`MSC_IRQ_BO] = bo_ev; // see [R25]
    end

    assign ev_clr = irq_ack
        | ((wr_go && avs_address == `MSC_OFF_FLAGS) ? wd[4:0] : 5'h00); // see [R20]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= 5'h00;
        end else begin
            flags_r <= ev_set | (flags_r & ~ev_clr); // see [R19]
        end
    end

    assign irq_req = flags_r & mask_r; // see [R19]
    assign wake_req = |irq_req; // see [R21]
endmodule
`default_nettype wire

// ===== msc_cpu_model.sv
/* Processor core model: an Avalon-MM master for the symbol counter.
   Assumes one clock shared with the slave. */
`timescale 1ns/1ps
`default_nettype none
module msc_cpu_model (
    input wire logic clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest
);
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    end

    // The request is held until the edge that sees waitrequest low.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        @(posedge clk iff !avs_waitrequest);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== msc_symbol_counter_checker.sv
/* Bus and event checker of the symbol counter.
   Assumes it is bound to the top and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.svh"
module msc_symbol_counter_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`MSC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [4:0] irq_ack,
    input wire logic [4:0] irq_req,
    input wire logic wake_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic req;
    assign req = avs_read || avs_write;
    sequence s_first;
        $rose(req);
    endsequence
    sequence s_done;
        req && !avs_waitrequest;
    endsequence
    sequence s_reg_wr(logic [7:0] a);
        s_done ##0 (avs_write && avs_byteenable[0] && avs_address == a);
    endsequence
    a_wait_first: assert property (s_first |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("access not two cycles");
    a_ready_late: assert property (s_done |-> $past(avs_waitrequest))
        else $error("ready without wait cycle");
    a_idle_ready: assert property (!req |-> !avs_waitrequest)
        else $error("wait while idle");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    a_wake_any: assert property (wake_req == (|irq_req))
        else $error("wake not tied to requests");
    a_ack_clears: assert property ((irq_ack & irq_req) != 0 |=>
        (irq_req & $past(irq_ack)) == 0)
        else $error("acknowledge left flag");
    a_flag_wclear: assert property (s_reg_wr(`MSC_OFF_FLAGS) |=>
        (irq_req & $past(avs_writedata[4:0])) == 0)
        else $error("written one left flag");
    a_mask_gates: assert property (s_reg_wr(`MSC_OFF_MASK) |=>
        (irq_req & ~$past(avs_writedata[4:0])) == 0)
        else $error("masked request raised");
endmodule
bind msc_symbol_counter msc_symbol_counter_checker msc_symbol_counter_checker_inst (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_ack(irq_ack), .irq_req(irq_req), .wake_req(wake_req));
`default_nettype wire

// ===== tb.sv
/* Self-checking testbench of the symbol counter.
   Assumes the processor model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.svh"
module tb;
    logic clk, rst_b, trx_sleep, trx_off, rx_fcs_ok, rx_is_beacon, avs_read, avs_write;
    logic avs_waitrequest, wake_req;
    logic [6:0] rx_len;
    logic [15:0] rx_src_pan, pan;
    logic [31:0] tx_frame_stamp, avs_writedata, avs_readdata;
    logic [7:0] avs_address, r, e, m;
    logic [3:0] avs_byteenable;
    logic [4:0] irq_req;
    logic [8:0] pl;
    logic [7:0] e_q[$], m_q[$];
    int errors = 0, total_checks = 0;

    msc_symbol_counter #(.SYM_DIV(16), .BO_SYMS(20)) msc_symbol_counter_inst (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rtc_tick(pl[0]),
        .trx_sleep(trx_sleep), .trx_off(trx_off), .rx_sfd_det(pl[1]), .rx_len_strobe(pl[2]),
        .rx_len(rx_len), .rx_end(pl[3]), .rx_fcs_ok(rx_fcs_ok), .rx_is_beacon(rx_is_beacon),
        .rx_src_pan(rx_src_pan), .network_ident_low(pan[7:0]), .network_ident_high(pan[15:8]),
        .tx_frame_stamp(tx_frame_stamp), .irq_ack(pl[8:4]), .irq_req(irq_req),
        .wake_req(wake_req));
    msc_cpu_model msc_cpu_model_inst (.clk(clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));

    // ------
    // Tasks
    // ------
    task automatic rd(input logic [7:0] a, input logic [7:0] ev, input logic [7:0] mv = 8'hFF);
        e_q.push_back(ev);
        m_q.push_back(mv);
        msc_cpu_model_inst.xfer(1'h0, a, 8'h00, 4'hF);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
        msc_cpu_model_inst.xfer(1'h1, a, d, be);
    endtask
    task automatic rdw(input logic [2:0] g, input logic [31:0] v);
        for (int n = 0; n < 4; n++) begin
            rd({1'h0, g, 2'(n), 2'h0}, v[8*n+:8]);
        end
    endtask
    task automatic wrw(input logic [2:0] g, input logic [31:0] v);
        for (int n = 3; n >= 0; n--) begin
            wr({1'h0, g, 2'(n), 2'h0}, v[8*n+:8]);
        end
    endtask
    task automatic pulse(input logic [8:0] p);
        @(posedge clk);
        pl <= p;
        @(posedge clk);
        pl <= 9'h000;
    endtask
    task automatic ck(input logic [5:0] ev, input logic [5:0] mv);
        @(negedge clk);
        total_checks++;
        if (({wake_req, irq_req} & mv) !== ev) begin
            errors++;
            $display("MISMATCH irq expected %h seen %h", ev, {wake_req, irq_req} & mv);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest) begin
            e = e_q.pop_front();
            m = m_q.pop_front();
            total_checks++;
            if ((avs_readdata[7:0] & m) !== e) begin
                errors++;
                $display("MISMATCH reg %h expected %h seen %h", avs_address, e,
                         avs_readdata[7:0] & m);
            end
        end
    end

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // ------
    // Stimulus
    // ------
    initial begin
        rst_b = 1'h0;
        {trx_sleep, trx_off, rx_len, rx_src_pan, tx_frame_stamp, pl} = '0;
        {rx_fcs_ok, rx_is_beacon} = 2'h3;
        pan = 16'h1234;
        r = 8'($urandom(32'hD3FE) % 8) + 8'h04;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        rd(`MSC_OFF_STATUS, 8'h00);
        rd(8'h7C, 8'h00);
        wr(`MSC_OFF_CTRL0, 8'h01, 4'h0);
        rd(`MSC_OFF_CTRL0, 8'h00);
        trx_sleep <= 1'h1;
        wrw(3'h0, 32'h1234_5678);
        rd(`MSC_OFF_STATUS, 8'h03);
        pulse(9'h001);
        rd(`MSC_OFF_STATUS, 8'h02);
        rdw(3'h0, 32'h1234_5678);
        pulse(9'h002);
        rx_len <= 7'h05;
        pulse(9'h004);
        rdw(3'h1, 32'h0);
        wr(`MSC_OFF_CTRL0, 8'h01);
        pulse(9'h002);
        rx_len <= 7'h00;
        pulse(9'h004);
        rdw(3'h1, 32'h0);
        rx_len <= 7'h05;
        pulse(9'h004);
        rdw(3'h1, 32'h1234_5678);
        rx_src_pan <= 16'h1111;
        pulse(9'h008);
        rdw(3'h2, 32'h0);
        pan <= 16'hFFFF;
        pulse(9'h008);
        rdw(3'h2, 32'h1234_5678);
        wrw(3'h2, 32'h0);
        rx_fcs_ok <= 1'h0;
        pulse(9'h008);
        rdw(3'h2, 32'h0);
        wr(`MSC_OFF_CTRL0, 8'h05);
        rd(`MSC_OFF_CTRL0, 8'h01, 8'h05);
        rdw(3'h2, 32'h1234_5678);
        trx_sleep <= 1'h0;
        wrw(3'h0, 32'hFFFF_FFFF);
        repeat (40) @(posedge clk);
        rd(`MSC_OFF_FLAGS, 8'h08, 8'h08);
        ck(6'h00, 6'h08);
        wr(`MSC_OFF_MASK, 8'h08);
        ck(6'h28, 6'h28);
        wr(`MSC_OFF_FLAGS, 8'h08);
        rd(`MSC_OFF_FLAGS, 8'h00, 8'h08);
        wr(`MSC_OFF_MASK, 8'h10);
        repeat (340) @(posedge clk);
        ck(6'h30, 6'h30);
        // Radio off first, so no backoff event can meet the acknowledge.
        trx_off <= 1'h1;
        pulse(9'h100);
        ck(6'h00, 6'h10);
        repeat (700) @(posedge clk);
        ck(6'h00, 6'h10);
        // Offsets lie well past any frame so the stamps are settled first.
        tx_frame_stamp <= 32'h0000_0200;
        wrw(3'h2, 32'h0000_01F0);
        wrw(3'h3, 32'hEDCB_AB8C);
        wrw(3'h4, 32'h0000_0018);
        wrw(3'h5, {24'h000000, r});
        wr(`MSC_OFF_RELSRC, 8'h12);
        wr(`MSC_OFF_FLAGS, 8'h1F);
        wr(`MSC_OFF_MATCH, 8'h77);
        wrw(3'h0, 32'h0000_0200);
        repeat (320) @(posedge clk);
        rd(`MSC_OFF_FLAGS, 8'h07, 8'h07);
        wr(`MSC_OFF_FLAGS, 8'h1F);
        wr(`MSC_OFF_MATCH, 8'h01);
        wrw(3'h3, 32'h0000_0304);
        wrw(3'h0, 32'h0000_0300);
        repeat (100) @(posedge clk);
        rd(`MSC_OFF_FLAGS, 8'h01, 8'h07);
        final_report();
    end
endmodule
`default_nettype wire
